// [src/rtc_regs.sv]
// Operation
// RL1: alarm two flag reads zero whenever alarm two enable is clear
// RL2: with alarm two off, 14h-18h store every written bit as plain storage
// RL3: software writes zero to reserved bits, except alarm two storage bits
// RL4: bit 5 of 0Ah lets alarms keep signalling on backup battery
// RL5: alarm interrupts gated by 0Ah bit 7 and 14h bit 7
// RL6: 09h bit 7 gates the oscillator fail flag onto the interrupt
// RL7: 11h holds run, irq/pulse select, irq enable and two-bit rate select
// RL8: alarm one repeat bits: bit 7 of 0Bh-0Eh plus 0Bh bit 6
// RL9: alarm two repeat bits: bit 7 of 15h-18h plus 15h bit 6
// RL10: 08h holds trim sign bit 5, magnitude bits 4-0, freq test bit 6
// RL11: 12h holds load trim sign bit 7 and magnitude bits 6-0
// RL12: flags report watchdog, alarms, battery, timer, oscillator in bits 7-2
// RL13: seven user bytes at 19h-1Fh hold the last written value
// RL14: time write while frozen copies held buffer plus new field to counters
// RL15: software clears freeze bit at power-up before writing time registers
// RL16: trim sign one speeds the clock up, zero slows it down
`timescale 1ns/1ps
`default_nettype none
module rtc_regs
  import rtc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic link_clk,
  input wire logic link_wr,
  input wire logic link_rd,
  input wire logic [rtc_pkg::ADDR_W-1:0] link_addr,
  input wire logic [rtc_pkg::DATA_W-1:0] link_wdata,
  output logic [rtc_pkg::DATA_W-1:0] link_rdata,
  output logic link_done,
  output logic link_busy,
  input wire logic tick_pin,
  input wire logic watchdog_expire_pin,
  input wire logic alarm_one_match_pin,
  input wire logic alarm_two_match_pin,
  input wire logic battery_low_pin,
  input wire logic timer_expire_pin,
  input wire logic osc_fail_pin,
  input wire logic on_battery_pin,
  output logic irq_n,
  output logic osc_freeze,
  output logic freeze_update,
  output logic freq_test_en,
  output logic digital_trim_sign,
  output logic trim_speed_up,
  output logic [4:0] digital_trim_magnitude,
  output logic load_cap_trim_sign,
  output logic [6:0] load_cap_trim_value,
  output logic [7:0] watchdog_setting,
  output logic timer_run,
  output logic timer_irq_or_pulse_sel,
  output logic [1:0] timer_rate_sel,
  output logic [7:0] countdown_preset,
  output logic square_wave_en,
  output logic [3:0] square_wave_rate,
  output logic alarm_two_enable,
  output logic [4:0] alarm_one_repeat_sel,
  output logic [4:0] alarm_two_repeat_sel
);

  ////////////////////////////////////////////////////////////////////////////
  // link side state

  typedef enum logic {L_IDLE, L_WAIT} link_state_e;

  typedef struct packed {
    link_state_e state;
    logic req_tog;
    logic we;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [1:0] ack_sync;
    logic [DATA_W-1:0] rdata;
    logic done;
  } link_s;

  ////////////////////////////////////////////////////////////////////////////
  // system side state

  typedef enum logic {S_IDLE, S_READ} sys_state_e;

  typedef struct packed {
    sys_state_e state;
    logic [2:0] req_sync;
    logic ack_tog;
    logic [PIN_N-1:0] pin_s1;
    logic [PIN_N-1:0] pin_s2;
    logic [PIN_N-1:0] pin_prev;
    logic [ADDR_W-1:0] op_addr;
    logic [DATA_W-1:0] rdata;
    logic [7:0][7:0] cnt;
    logic [7:0][7:0] hold;
    logic [24:8][7:0] ctl;
    logic [7:2] flags;
    logic irq_n;
  } sys_s;

  link_s l;
  link_s next_l;
  sys_s s;
  sys_s next_s;

  logic [PIN_N-1:0] pins;
  logic [PIN_N-1:0] rise;
  logic [DATA_W-1:0] user_q;
  logic user_we;
  logic [2:0] user_wa;
  logic [2:0] user_ra;
  logic req_new;
  logic al2_en;
  logic on_bat;
  logic alarm_irq;
  logic level_irq;
  logic pulse_irq;

  // bcd increment with carry out, wraps past top
  function automatic logic [8:0] bcd_inc(input logic [7:0] v,
                                         input logic [7:0] top);
    logic [8:0] r;
    r = '0;
    if (v == top) begin
      r = {1'b1, 8'h00};
    end else if (v[3:0] == 4'h9) begin
      r = {1'b0, v[7:4] + 4'h1, 4'h0};
    end else begin
      r = {1'b0, v[7:4], v[3:0] + 4'h1};
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // link domain: take one request, wait for the system side to answer

  always_comb begin
    next_l = l;
    next_l.done = 1'b0;
    next_l.ack_sync = {l.ack_sync[0], s.ack_tog};
    case (l.state)
      L_IDLE: begin
        if ((link_wr || link_rd) && !l.done) begin // no retake
          next_l.we = link_wr;
          next_l.addr = link_addr;
          next_l.wdata = link_wdata;
          next_l.req_tog = ~l.req_tog;
          next_l.state = L_WAIT;
        end
      end
      L_WAIT: begin
        // answer word is stable once the toggle has come back
        if (l.ack_sync[1] == l.req_tog) begin
          next_l.rdata = s.rdata;
          next_l.done = 1'b1;
          next_l.state = L_IDLE;
        end
      end
      default: begin
        next_l.state = L_IDLE;
      end
    endcase
  end

  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      l <= '0;
    end else begin
      l <= next_l;
    end
  end

  assign link_rdata = l.rdata;
  assign link_done = l.done;
  assign link_busy = (l.state == L_WAIT);

  ////////////////////////////////////////////////////////////////////////////
  // system domain helpers

  assign pins = {on_battery_pin, osc_fail_pin, timer_expire_pin,
                 battery_low_pin, alarm_two_match_pin, alarm_one_match_pin,
                 watchdog_expire_pin, tick_pin};
  assign rise = s.pin_s2 & ~s.pin_prev;
  assign req_new = (s.req_sync[1] != s.req_sync[2]);
  assign al2_en = s.ctl[A_SQW][B_AL2_EN];
  assign on_bat = s.pin_s2[P_ONBAT];

  // user storage port
  assign user_we = (s.state == S_IDLE) && req_new && l.we &&
                   (l.addr >= A_USER_FIRST);
  assign user_wa = 3'(l.addr - A_USER_FIRST);
  assign user_ra = 3'(l.addr - A_USER_FIRST);

  // interrupt sources
  assign alarm_irq = ((s.flags[F_AF1] & s.ctl[A_ALARM_ONE_MONTH][B_IRQ_EN]) |
                      (s.flags[F_AF2] & al2_en &
                       s.ctl[A_AL2_MONTH][B_IRQ_EN])) &     // [RL5]
                     (~on_bat | s.ctl[A_ALARM_ONE_MONTH][B_ALM_BAT]); // [RL4]
  assign level_irq = alarm_irq |
                     (s.flags[F_OF] & s.ctl[A_WDOG][B_IRQ_EN]) | // [RL6]
                     (s.flags[F_TF] & s.ctl[A_CNT_CTRL][B_TMR_IE] &
                      ~s.ctl[A_CNT_CTRL][B_TMR_SEL]);        // [RL7]
  assign pulse_irq = rise[P_TMR] & s.ctl[A_CNT_CTRL][B_TMR_IE] &
                     s.ctl[A_CNT_CTRL][B_TMR_SEL];           // [RL7]

  ////////////////////////////////////////////////////////////////////////////
  // system domain: counters, register file, flags

  always_comb begin
    logic [8:0] frac;
    logic [8:0] secs;
    logic [4:0] a;
    logic [7:0] wd;
    frac = '0;
    secs = '0;
    a = l.addr;
    wd = l.wdata;
    next_s = s;
    next_s.pin_s1 = pins;
    next_s.pin_s2 = s.pin_s1;
    next_s.pin_prev = s.pin_s2;
    next_s.req_sync = {s.req_sync[1], s.req_sync[0], l.req_tog};

    // held buffer follows the counters unless frozen
    if (!s.ctl[A_ALARM_ONE_HOUR][B_FREEZE_UPD]) begin
      next_s.hold = s.cnt;
    end

    // hundredths tick advances fraction and seconds
    if (rise[P_TICK] && !s.cnt[A_SECONDS][B_OSC_FREEZE]) begin
      frac = bcd_inc(s.cnt[A_FRACTION], BCD_FRAC_TOP);
      next_s.cnt[A_FRACTION] = frac[7:0];
      if (frac[8]) begin
        secs = bcd_inc({1'b0, s.cnt[A_SECONDS][6:0]}, BCD_SEC_TOP);
        next_s.cnt[A_SECONDS][6:0] = secs[6:0];
      end
    end

    case (s.state)
      S_IDLE: begin
        if (req_new) begin
          next_s.op_addr = a;
          next_s.state = S_READ;
          if (l.we) begin
            if (a <= A_TIME_LAST) begin
              // buffer with the new field goes back to the counters
              next_s.cnt = s.hold;                               // [RL14]
              next_s.cnt[a[2:0]] = wd & WMASK[a];                // [RL14]
              next_s.hold[a[2:0]] = wd & WMASK[a];
            end else if (a == A_FLAGS) begin
              // writing zero clears a flag
              next_s.flags = s.flags & wd[7:2];
            end else if (a >= A_AL2_MONTH && a <= A_AL2_SEC) begin
              next_s.ctl[a] = wd;                                // [RL2]
            end else if (a < A_USER_FIRST) begin
              next_s.ctl[a] = wd & WMASK[a];    // [RL7] [RL10] [RL11]
            end
          end
        end
      end
      S_READ: begin
        // answer built once user storage data are out
        if (s.op_addr <= A_TIME_LAST) begin
          next_s.rdata = s.hold[s.op_addr[2:0]];
        end else if (s.op_addr == A_FLAGS) begin
          next_s.rdata = {s.flags[F_WDF], s.flags[F_AF1],
                          s.flags[F_AF2] & al2_en,               // [RL1]
                          s.flags[F_BL], s.flags[F_TF],
                          s.flags[F_OF], 2'b00};                 // [RL12]
        end else if (s.op_addr >= A_USER_FIRST) begin
          next_s.rdata = user_q;                                 // [RL13]
        end else if (s.op_addr >= A_AL2_MONTH && !al2_en) begin
          next_s.rdata = s.ctl[s.op_addr];                       // [RL2]
        end else begin
          next_s.rdata = s.ctl[s.op_addr] & WMASK[s.op_addr];
        end
        next_s.ack_tog = ~s.ack_tog;
        next_s.state = S_IDLE;
      end
      default: begin
        next_s.state = S_IDLE;
      end
    endcase

    // events set flags after any clear, so a set is never lost
    if (rise[P_WDOG]) next_s.flags[F_WDF] = 1'b1;                // [RL12]
    if (rise[P_AL1]) next_s.flags[F_AF1] = 1'b1;
    if (rise[P_AL2]) next_s.flags[F_AF2] = 1'b1;
    if (rise[P_BATLOW]) next_s.flags[F_BL] = 1'b1;
    if (rise[P_TMR]) next_s.flags[F_TF] = 1'b1;
    if (rise[P_OSC]) next_s.flags[F_OF] = 1'b1;

    // entering battery mode freezes the held time
    if (rise[P_ONBAT]) begin
      next_s.ctl[A_ALARM_ONE_HOUR][B_FREEZE_UPD] = 1'b1;
    end

    next_s.irq_n = ~(level_irq | pulse_irq);
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.irq_n <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // user storage bytes

  rtc_store #(
    .WIDTH(DATA_W),
    .DEPTH(USER_DEPTH)
  ) user_bytes (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .wr_en(user_we),
    .wr_addr(user_wa),
    .wr_data(l.wdata),
    .rd_addr(user_ra),
    .rd_data(user_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  // control outputs straight from register bits

  assign irq_n = s.irq_n;
  assign osc_freeze = s.cnt[A_SECONDS][B_OSC_FREEZE];
  assign freeze_update = s.ctl[A_ALARM_ONE_HOUR][B_FREEZE_UPD];
  assign freq_test_en = s.ctl[A_DTRIM][B_FREQ_TEST];             // [RL10]
  assign digital_trim_sign = s.ctl[A_DTRIM][B_DTRIM_SIGN];       // [RL10]
  assign trim_speed_up = s.ctl[A_DTRIM][B_DTRIM_SIGN];           // [RL16]
  assign digital_trim_magnitude = s.ctl[A_DTRIM][4:0];           // [RL10]
  assign load_cap_trim_sign = s.ctl[A_LCAP][7];                  // [RL11]
  assign load_cap_trim_value = s.ctl[A_LCAP][6:0];               // [RL11]
  assign watchdog_setting = s.ctl[A_WDOG];
  assign timer_run = s.ctl[A_CNT_CTRL][B_TMR_RUN];               // [RL7]
  assign timer_irq_or_pulse_sel = s.ctl[A_CNT_CTRL][B_TMR_SEL];  // [RL7]
  assign timer_rate_sel = s.ctl[A_CNT_CTRL][1:0];                // [RL7]
  assign countdown_preset = s.ctl[A_CNT_VAL];
  assign square_wave_en = s.ctl[A_ALARM_ONE_MONTH][B_SQW_EN];
  assign square_wave_rate = s.ctl[A_SQW][7:4];
  assign alarm_two_enable = al2_en;
  assign alarm_one_repeat_sel = {s.ctl[A_ALARM_ONE_DATE][B_RPT_HI],
                                 s.ctl[A_ALARM_ONE_DATE][B_RPT],
                                 s.ctl[A_ALARM_ONE_HOUR][B_RPT],
                                 s.ctl[A_ALARM_ONE_MINUTE][B_RPT],
                                 s.ctl[A_ALARM_ONE_SECOND][B_RPT]};       // [RL8]
  assign alarm_two_repeat_sel = {s.ctl[A_AL2_DATE][B_RPT_HI],
                                 s.ctl[A_AL2_DATE][B_RPT],
                                 s.ctl[A_AL2_HOUR][B_RPT],
                                 s.ctl[A_AL2_MIN][B_RPT],
                                 s.ctl[A_AL2_SEC][B_RPT]};       // [RL9]

endmodule
`default_nettype wire

// [src/rtc_pkg.sv]
package rtc_pkg;

  // access port widths
  localparam int ADDR_W = 5;
  localparam int DATA_W = 8;
  localparam int USER_DEPTH = 7;

  // register offsets
  localparam logic [4:0] A_FRACTION = 5'h00;
  localparam logic [4:0] A_SECONDS = 5'h01;
  localparam logic [4:0] A_TIME_LAST = 5'h07;
  localparam logic [4:0] A_DTRIM = 5'h08;
  localparam logic [4:0] A_WDOG = 5'h09;
  localparam logic [4:0] A_ALARM_ONE_MONTH = 5'h0A;
  localparam logic [4:0] A_ALARM_ONE_DATE = 5'h0B;
  localparam logic [4:0] A_ALARM_ONE_HOUR = 5'h0C;
  localparam logic [4:0] A_ALARM_ONE_MINUTE = 5'h0D;
  localparam logic [4:0] A_ALARM_ONE_SECOND = 5'h0E;
  localparam logic [4:0] A_FLAGS = 5'h0F;
  localparam logic [4:0] A_CNT_VAL = 5'h10;
  localparam logic [4:0] A_CNT_CTRL = 5'h11;
  localparam logic [4:0] A_LCAP = 5'h12;
  localparam logic [4:0] A_SQW = 5'h13;
  localparam logic [4:0] A_AL2_MONTH = 5'h14;
  localparam logic [4:0] A_AL2_DATE = 5'h15;
  localparam logic [4:0] A_AL2_HOUR = 5'h16;
  localparam logic [4:0] A_AL2_MIN = 5'h17;
  localparam logic [4:0] A_AL2_SEC = 5'h18;
  localparam logic [4:0] A_USER_FIRST = 5'h19;

  // field positions
  localparam int B_OSC_FREEZE = 7;
  localparam int B_FREEZE_UPD = 6;
  localparam int B_ALM_BAT = 5;
  localparam int B_IRQ_EN = 7;
  localparam int B_SQW_EN = 6;
  localparam int B_AL2_EN = 1;
  localparam int B_TMR_RUN = 7;
  localparam int B_TMR_SEL = 6;
  localparam int B_TMR_IE = 5;
  localparam int B_FREQ_TEST = 6;
  localparam int B_DTRIM_SIGN = 5;
  localparam int B_RPT = 7;
  localparam int B_RPT_HI = 6;
  localparam int F_WDF = 7;
  localparam int F_AF1 = 6;
  localparam int F_AF2 = 5;
  localparam int F_BL = 4;
  localparam int F_TF = 3;
  localparam int F_OF = 2;

  // event pin positions
  localparam int P_TICK = 0;
  localparam int P_WDOG = 1;
  localparam int P_AL1 = 2;
  localparam int P_AL2 = 3;
  localparam int P_BATLOW = 4;
  localparam int P_TMR = 5;
  localparam int P_OSC = 6;
  localparam int P_ONBAT = 7;
  localparam int PIN_N = 8;

  // reset values and bcd limits
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] BCD_FRAC_TOP = 8'h99;
  localparam logic [7:0] BCD_SEC_TOP = 8'h59;

  // writable bits per address, reserved bits cleared
  localparam logic [7:0] WMASK [32] = '{
    8'hFF, 8'hFF, 8'h7F, 8'hFF, 8'h07, 8'h3F, 8'h1F, 8'hFF,
    8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFC,
    8'hFF, 8'hE3, 8'hFF, 8'hF3, 8'h9F, 8'hFF, 8'hBF, 8'hFF,
    8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};

endpackage

// [src/rtc_store.sv]
`timescale 1ns/1ps
`default_nettype none
module rtc_store #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 7
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [2:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [2:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [WIDTH-1:0] q;
  } store_s;

  store_s s;
  store_s next_s;

  // write port and registered read port
  always_comb begin
    next_s = s;
    if (wr_en && (32'(wr_addr) < DEPTH)) begin
      next_s.mem[wr_addr] = wr_data;
    end
    if (32'(rd_addr) < DEPTH) begin
      next_s.q = s.mem[rd_addr];
    end else begin
      next_s.q = '0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign rd_data = s.q;

endmodule
`default_nettype wire

// [dv/rtc_regs_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module rtc_regs_asserts (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic link_clk,
  input wire logic link_wr,
  input wire logic link_rd,
  input wire logic link_busy,
  input wire logic link_done,
  input wire logic [7:0] link_rdata,
  input wire logic digital_trim_sign,
  input wire logic trim_speed_up,
  input wire logic [1:0] timer_rate_sel,
  input wire logic [6:0] load_cap_trim_value
);
  // request taken, then answered within the bound
  sequence s_take;
    (link_wr || link_rd) && !link_busy && !link_done;
  endsequence
  sequence s_answer;
    ##[4:7] link_done;
  endsequence
  a_take_busy: assert property (
    @(posedge link_clk) disable iff (!rst_n) s_take |=> link_busy)
    else $error("busy not raised");
  a_take_done: assert property (
    @(posedge link_clk) disable iff (!rst_n) s_take |-> s_answer)
    else $error("answer late or missing");
  a_busy_drop: assert property (
    @(posedge link_clk) disable iff (!rst_n) $fell(link_busy) |-> link_done)
    else $error("busy fell without done");
  a_done_once: assert property (
    @(posedge link_clk) disable iff (!rst_n) link_done |=> !link_done)
    else $error("done longer than one cycle");
  a_done_idle: assert property (
    @(posedge link_clk) disable iff (!rst_n) link_done |-> !link_busy)
    else $error("busy in done cycle");
  a_rdata_hold: assert property (
    @(posedge link_clk) disable iff (!rst_n)
    !link_done |-> $stable(link_rdata)) else $error("rdata moved");
  a_trim_dir: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    trim_speed_up == digital_trim_sign) else $error("trim direction");
  a_rate_write: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    $changed(timer_rate_sel) |-> link_busy || link_done)
    else $error("rate moved without write");
  a_lcap_write: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    $changed(load_cap_trim_value) |-> link_busy || link_done)
    else $error("load trim moved without write");
endmodule
bind rtc_regs rtc_regs_asserts u_chk (.clk_sys, .rst_n, .link_clk, .link_wr,
  .link_rd, .link_busy, .link_done, .link_rdata, .digital_trim_sign,
  .trim_speed_up, .timer_rate_sel, .load_cap_trim_value);
`default_nettype wire

// [dv/host_link.sv]
`timescale 1ns/1ps
`default_nettype none
module host_link (
  input wire logic link_clk,
  output logic link_wr,
  output logic link_rd,
  output logic [4:0] link_addr,
  output logic [7:0] link_wdata,
  input wire logic [7:0] link_rdata,
  input wire logic link_done
);
  // idle lines at time zero
  initial begin
    link_wr = 1'b0;
    link_rd = 1'b0;
    link_addr = 5'h00;
    link_wdata = 8'h00;
  end
  ////////////////////////////////////////
  // one request held until done is sampled
  task automatic access(input logic wr, input logic [4:0] a,
    input logic [7:0] d, output logic [7:0] q, output logic ok);
    int n;
    @(negedge link_clk);
    link_wr = wr;
    link_rd = !wr;
    link_addr = a;
    link_wdata = d;
    ok = 1'b0;
    q = 8'h00;
    // done looked at mid-cycle, where it is settled
    for (n = 0; n < 20 && !ok; n++) begin
      @(negedge link_clk);
      if (link_done === 1'b1) begin
        ok = 1'b1;
      end
    end
    // request held through the edge that samples done
    @(posedge link_clk);
    if (ok) begin
      q = link_rdata;
    end
    @(negedge link_clk);
    link_wr = 1'b0;
    link_rd = 1'b0;
    link_addr = ~a; // released lines do not keep old value
    link_wdata = ~d;
  endtask
endmodule
`default_nettype wire

// [dv/rtc_regs_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module rtc_regs_tb;
  import rtc_pkg::*;
  logic clk_sys, rst_n, link_clk, link_wr, link_rd, link_done, link_busy;
  logic [4:0] link_addr;
  logic [7:0] link_wdata, link_rdata, ev;
  logic irq_n, freq_test_en, digital_trim_sign, trim_speed_up;
  logic load_cap_trim_sign, timer_run, timer_irq_or_pulse_sel;
  logic square_wave_en, alarm_two_enable;
  logic [4:0] digital_trim_magnitude, alarm_one_repeat_sel;
  logic [4:0] alarm_two_repeat_sel;
  logic [6:0] load_cap_trim_value;
  logic [1:0] timer_rate_sel;
  logic [3:0] square_wave_rate;
  logic osc_freeze, freeze_update;
  logic [7:0] watchdog_setting, countdown_preset;
  int err_count = 0;
  int n_checks = 0;
  int i;
  ////////////////////////////////////////
  // clocks, link clock offset in phase
  always #12.5 clk_sys = ~clk_sys;
  initial begin
    link_clk = 1'b0;
    #7;
    forever #24 link_clk = ~link_clk;
  end
  rtc_regs DUT (.clk_sys, .rst_n, .link_clk, .link_wr, .link_rd, .link_addr,
    .link_wdata, .link_rdata, .link_done, .link_busy,
    .tick_pin(ev[P_TICK]), .watchdog_expire_pin(ev[P_WDOG]),
    .alarm_one_match_pin(ev[P_AL1]), .alarm_two_match_pin(ev[P_AL2]),
    .battery_low_pin(ev[P_BATLOW]), .timer_expire_pin(ev[P_TMR]),
    .osc_fail_pin(ev[P_OSC]), .on_battery_pin(ev[P_ONBAT]), .irq_n,
    .osc_freeze, .freeze_update, .freq_test_en, .digital_trim_sign,
    .trim_speed_up, .digital_trim_magnitude, .load_cap_trim_sign,
    .load_cap_trim_value, .watchdog_setting, .timer_run,
    .timer_irq_or_pulse_sel, .timer_rate_sel, .countdown_preset,
    .square_wave_en, .square_wave_rate, .alarm_two_enable,
    .alarm_one_repeat_sel, .alarm_two_repeat_sel);
  host_link host (.link_clk, .link_wr, .link_rd, .link_addr, .link_wdata,
    .link_rdata, .link_done);
  ////////////////////////////////////////
  // verdict and end of run
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [4:0] a,
    input logic [7:0] d, output logic [7:0] q);
    logic ok;
    host.access(w, a, d, q, ok);
    if (!ok) begin
      err_count++;
      wrap_up();
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] q;
    xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    logic [7:0] q;
    xfer(1'b0, a, 8'h00, q);
    chk8(q, e);
  endtask
  // event pin rise held past the synchroniser
  task automatic pulse(input int p);
    @(negedge clk_sys);
    ev[p] = 1'b1;
    repeat (3) @(negedge clk_sys);
    ev[p] = 1'b0;
    repeat (4) @(negedge clk_sys);
  endtask
  task automatic irq_is(input logic e);
    repeat (3) @(negedge clk_sys);
    chk8({7'h00, irq_n}, {7'h00, e});
  endtask
  ////////////////////////////////////////
  // main sequence
  initial begin
    clk_sys = 1'b0;
    rst_n = 1'b0;
    ev = 8'h00;
    repeat (6) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (4) @(posedge link_clk);
    for (i = 0; i < 32; i++) rd(i[4:0], RST_BYTE);
    irq_is(1'b1);
    $display("test reset done");
    wr(A_DTRIM, 8'h65);
    rd(A_DTRIM, 8'h65);
    chk8({3'h0, digital_trim_magnitude}, 8'h05);
    chk8({6'h00, freq_test_en, digital_trim_sign}, 8'h03);
    chk8({7'h00, trim_speed_up}, 8'h01);
    wr(A_DTRIM, 8'h0A);
    chk8({7'h00, trim_speed_up}, 8'h00);
    wr(A_LCAP, 8'hC3);
    chk8({load_cap_trim_sign, load_cap_trim_value}, 8'hC3);
    wr(A_CNT_CTRL, 8'hE2);
    rd(A_CNT_CTRL, 8'hE2);
    chk8({timer_run, timer_irq_or_pulse_sel, 4'h0, timer_rate_sel},
      8'hC2);
    wr(A_CNT_VAL, 8'h5A);
    chk8(countdown_preset, 8'h5A);
    $display("test trims done");
    wr(A_ALARM_ONE_DATE, 8'hC0);
    wr(A_ALARM_ONE_HOUR, 8'h80);
    wr(A_ALARM_ONE_MINUTE, 8'h00);
    wr(A_ALARM_ONE_SECOND, 8'h80);
    chk8({3'h0, alarm_one_repeat_sel}, 8'h1D);
    wr(A_AL2_MONTH, 8'hFF);
    rd(A_AL2_MONTH, 8'hFF);
    wr(A_AL2_DATE, 8'hC0);
    wr(A_AL2_HOUR, 8'hFF);
    rd(A_AL2_HOUR, 8'hFF);
    wr(A_AL2_MIN, 8'h00);
    wr(A_AL2_SEC, 8'h80);
    chk8({3'h0, alarm_two_repeat_sel}, 8'h1D);
    wr(A_SQW, 8'hA2);
    chk8({square_wave_rate, 3'h0, alarm_two_enable}, 8'hA1);
    rd(A_AL2_MONTH, 8'h9F);
    rd(A_AL2_HOUR, 8'hBF);
    $display("test alarm map done");
    wr(A_AL2_MONTH, 8'h00);
    wr(A_SQW, 8'h00);
    pulse(P_AL2);
    rd(A_FLAGS, 8'h00);
    wr(A_SQW, 8'h02);
    rd(A_FLAGS, 8'h20);
    pulse(P_WDOG);
    pulse(P_AL1);
    pulse(P_BATLOW);
    pulse(P_TMR);
    pulse(P_OSC);
    rd(A_FLAGS, 8'hFC);
    wr(A_FLAGS, 8'h00);
    rd(A_FLAGS, 8'h00);
    irq_is(1'b1);
    $display("test flags done");
    wr(A_WDOG, 8'h80);
    chk8(watchdog_setting, 8'h80);
    pulse(P_OSC);
    irq_is(1'b0);
    wr(A_WDOG, 8'h00);
    irq_is(1'b1);
    wr(A_FLAGS, 8'h00);
    wr(A_ALARM_ONE_MONTH, 8'h80);
    pulse(P_AL1);
    irq_is(1'b0);
    ev[P_ONBAT] = 1'b1;
    irq_is(1'b1);
    wr(A_ALARM_ONE_MONTH, 8'hE0);
    irq_is(1'b0);
    chk8({7'h00, square_wave_en}, 8'h01);
    $display("test interrupts done");
    // battery entry froze the buffer; a frozen time write copies it back
    chk8({7'h00, freeze_update}, 8'h01);
    repeat (3) pulse(P_TICK);
    rd(A_FRACTION, 8'h00);
    wr(A_SECONDS, 8'h46);
    wr(A_ALARM_ONE_HOUR, 8'h80);
    rd(A_FRACTION, 8'h00);
    rd(A_SECONDS, 8'h46);
    wr(A_SECONDS, 8'hC6);
    chk8({7'h00, osc_freeze}, 8'h01);
    pulse(P_TICK);
    rd(A_FRACTION, 8'h00);
    $display("test time done");
    // timer flag as a level interrupt, then masked by pulse select
    wr(A_FLAGS, 8'h00);
    irq_is(1'b1);
    wr(A_CNT_CTRL, 8'hA2);
    pulse(P_TMR);
    irq_is(1'b0);
    wr(A_CNT_CTRL, 8'hE2);
    irq_is(1'b1);
    $display("test timer done");
    for (i = 0; i < USER_DEPTH; i++) begin
      wr(A_USER_FIRST + i[4:0], 8'h3C ^ i[7:0]);
    end
    for (i = 0; i < USER_DEPTH; i++) begin
      rd(A_USER_FIRST + i[4:0], 8'h3C ^ i[7:0]);
    end
    $display("test storage done");
    wrap_up();
  end
endmodule
`default_nettype wire
